// ---- bench/ast_rx_model.sv ----
// far-end receiver model sampling the serial line
`timescale 1ns/100ps
module ast_rx_model (
  // clock
  input  wire logic        i_clk,
  // line and frame settings
  input  wire logic        i_line,
  input  wire logic        i_oe_n,
  input  wire logic        i_nine,
  input  wire logic [15:0] i_bit_cycles,
  // received frames
  output logic      [8:0]  o_data,
  output logic      [7:0]  o_count
);
  logic [8:0] sh;
  logic       ok;
  int         k;
  initial o_count = 8'h00;
  // sample mid-bit; a frame cut by a released pin is dropped
  always begin
    @(negedge i_line);
    sh = 9'h000;
    repeat (i_bit_cycles / 2) @(posedge i_clk);
    ok = !i_line;
    for (k = 0; k < (i_nine ? 9 : 8); k++) begin
      repeat (i_bit_cycles) @(posedge i_clk);
      sh[k] = i_line;
      ok = ok && !i_oe_n;
    end
    repeat (i_bit_cycles) @(posedge i_clk);
    if (ok && i_line && !i_oe_n) begin
      o_data = sh;
      o_count = o_count + 8'h01;
    end
  end
endmodule // ast_rx_model

// ---- bench/ast_top_assertions.sv ----
// port checker for the serial transmitter
`timescale 1ns/100ps
module ast_top_assertions (
  // clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  // watched ports
  input wire ast_pkg::ast_wr_req_t i_wr,
  input wire ast_pkg::ast_wr_rsp_t o_wr,
  input wire ast_pkg::ast_rd_req_t i_rd,
  input wire ast_pkg::ast_rd_rsp_t o_rd,
  input wire logic                 i_sleep,
  input wire logic                 o_tx_pin_out,
  input wire logic                 o_tx_pin_oe_n,
  input wire logic                 o_rx_pin_out,
  input wire logic                 o_rx_pin_oe_n
);
  import ast_pkg::*;
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // answer given, then taken by the master
  sequence s_wr_done;
    o_wr.bvalid && i_wr.bready ##1 !o_wr.bvalid;
  endsequence
  sequence s_rd_done;
    o_rd.rvalid && i_rd.rready ##1 !o_rd.rvalid;
  endsequence
  // register access answers
  a_wr_answer: assert property (
    i_wr.awvalid && o_wr.awready && i_wr.wvalid && o_wr.wready
    |-> ##[1:2] s_wr_done) else $error("write answer missing");
  a_rd_answer: assert property (
    i_rd.arvalid && o_rd.arready |-> ##[1:2] s_rd_done)
    else $error("read answer missing");
  a_wr_refuse: assert property (
    o_wr.bvalid |-> !o_wr.awready && !o_wr.wready)
    else $error("write taken while answering");
  // line level and pin direction
  a_reset_idle: assert property (
    $fell(i_rst) |-> o_tx_pin_out && o_tx_pin_oe_n && o_rx_pin_oe_n
    && !o_wr.bvalid && !o_rd.rvalid) else $error("bad state after reset");
  a_float_high: assert property (
    o_tx_pin_oe_n |-> o_tx_pin_out) else $error("released line not high");
  a_start_driven: assert property (
    $fell(o_tx_pin_out) |-> !o_tx_pin_oe_n) else $error("undriven low");
  a_release_why: assert property (
    $rose(o_tx_pin_oe_n) |-> $past(i_wr.wvalid, 3) || $past(i_wr.wvalid, 2)
    || $past(i_rst)) else $error("pin released without a write");
  a_sleep_hold: assert property (
    i_sleep && !i_wr.wvalid && !$past(i_wr.wvalid) && !$past(i_wr.wvalid, 2)
    |=> $stable(o_tx_pin_out)) else $error("line moved in sleep");
endmodule // ast_top_assertions

bind ast_top ast_top_assertions chk_u (.i_clk, .i_rst, .i_wr, .o_wr, .i_rd,
  .o_rd, .i_sleep, .o_tx_pin_out, .o_tx_pin_oe_n, .o_rx_pin_out,
  .o_rx_pin_oe_n);

// ---- bench/ast_top_bench.sv ----
// self-checking bench for the serial transmitter
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  miscompares++; $display("wrong value %s exp %h seen %h", n, e, s); end end
module ast_top_bench;
  import ast_pkg::*;
  logic        i_clk, i_rst, i_sleep, nine;
  logic        o_tx_pin_out, o_tx_pin_oe_n, o_rx_pin_out, o_rx_pin_oe_n;
  ast_wr_req_t i_wr;
  ast_wr_rsp_t o_wr;
  ast_rd_req_t i_rd;
  ast_rd_rsp_t o_rd, rs;
  logic [15:0] bit_cyc;
  logic [8:0]  got;
  logic [7:0]  cnt;
  int          miscompares = 0;
  int          check_count = 0;
  wire         line = o_tx_pin_oe_n ? 1'b1 : o_tx_pin_out; // pulled up
  // design and far-end receiver
  ast_top dut_u (.i_clk, .i_rst, .i_wr, .o_wr, .i_rd, .o_rd, .i_sleep,
    .o_tx_pin_out, .o_tx_pin_oe_n, .o_rx_pin_out, .o_rx_pin_oe_n);
  ast_rx_model far_u (.i_clk, .i_line(line), .i_oe_n(o_tx_pin_oe_n),
    .i_nine(nine), .i_bit_cycles(bit_cyc), .o_data(got), .o_count(cnt));
  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // bus cycles: each channel dropped once taken, then the answer
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= '{{ix, 2'b00}, 1'b1, {24'h0, d}, 4'hf, 1'b1, 1'b1};
    do begin
      @(posedge i_clk);
      if (o_wr.awready) i_wr.awvalid <= 1'b0;
      if (o_wr.wready) i_wr.wvalid <= 1'b0;
    end while (!o_wr.bvalid);
    i_wr.bready <= 1'b0;
    `CHK("bresp", 2'b00, o_wr.bresp)
  endtask
  task automatic rd(input logic [5:0] ix, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= '{{ix, 2'b00}, 1'b1, 1'b1};
    do begin
      @(posedge i_clk);
      if (o_rd.arready) i_rd.arvalid <= 1'b0;
    end while (!o_rd.rvalid);
    rs = o_rd;
    i_rd.rready <= 1'b0;
    `CHK("register", {24'h0, e}, rs.rdata)
  endtask
  task automatic frame(input logic [7:0] n, input logic [8:0] e);
    wait (cnt == n);
    `CHK("frame", e, got)
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (40000) @(posedge i_clk);
    miscompares++;
    conclude();
  end
  // tests
  initial begin
    {i_rst, i_sleep, nine, i_wr, i_rd} = '0;
    i_rst = 1'b1;
    bit_cyc = 16'd64;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(6'h15, 8'h02);
    wr(6'h18, 8'h00);
    rd(6'h18, 8'h02);
    rd(6'h3e, 8'h00);
    `CHK("resp", 2'b10, rs.rresp)
    wr(6'h17, 8'h00);
    wr(6'h13, 8'h80);
    wr(6'h15, 8'ha0);
    @(negedge i_clk);
    `CHK("oe", 2'b01, {o_tx_pin_oe_n, o_rx_pin_oe_n})
    wr(6'h16, 8'h5a);
    rd(6'h18, 8'h02);
    wr(6'h16, 8'hc3);
    rd(6'h18, 8'h00);
    wr(6'h15, 8'ha2);
    rd(6'h15, 8'ha0);
    frame(8'd1, 9'h05a);
    frame(8'd2, 9'h0c3);
    repeat (40) @(posedge i_clk);
    rd(6'h15, 8'ha2);
    wr(6'h17, 8'h01);
    bit_cyc = 16'd128;
    nine = 1'b1;
    wr(6'h15, 8'h61);
    wr(6'h16, 8'h81);
    frame(8'd3, 9'h181);
    wr(6'h15, 8'h60);
    wr(6'h16, 8'h0f);
    frame(8'd4, 9'h00f);
    wr(6'h17, 8'h00);
    bit_cyc = 16'd64;
    nine = 1'b0;
    wr(6'h15, 8'h20);
    i_sleep <= 1'b1;
    wr(6'h16, 8'ha5);
    repeat (300) @(posedge i_clk);
    `CHK("sleep", 10'h304, {line, o_rx_pin_out, cnt})
    i_sleep <= 1'b0;
    frame(8'd5, 9'h0a5);
    for (int k = 0; k < 2; k++) begin
      wr(6'h16, 8'h33);
      repeat (200) @(posedge i_clk);
      wr(k ? 6'h13 : 6'h15, 8'h00);
      repeat (2) @(posedge i_clk);
      `CHK("oe", 1'b1, o_tx_pin_oe_n)
      rd(6'h15, k ? 8'h22 : 8'h02);
      repeat (700) @(posedge i_clk);
      wr(6'h13, 8'h80);
      wr(6'h16, 8'h96);
      wr(6'h15, 8'h20);
      frame(8'(6 + k), 9'h096);
    end
    wr(6'h15, 8'h30);
    wr(6'h16, 8'h55);
    repeat (700) @(posedge i_clk);
    `CHK("sync", 8'd7, cnt)
    conclude();
  end
endmodule // ast_top_bench

// ---- logic/ast_baud_gen.sv ----
// baud divider giving one pulse per serial bit
`timescale 1ns/100ps
`include "ast_map.svh"
module ast_baud_gen (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // control
  input  wire logic       i_enable,
  input  wire logic       i_freeze,
  input  wire logic [7:0] i_divide,
  // tick out
  output logic            o_bit_tick
);
  import ast_pkg::*;

  logic [7:0] div_reg;
  logic [5:0] phase_reg;
  logic       x64_tick;

  // the divider expires every divide+1 clocks: one x64 tick
  assign x64_tick   = (div_reg == 8'h00);
  assign o_bit_tick = x64_tick && (phase_reg == `AST_PHASE_LAST);

  // phase clears and divider reloads while disabled; both hold while frozen
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_enable) begin
      div_reg   <= i_rst ? 8'h00 : i_divide;
      phase_reg <= 6'h00;
    end else if (!i_freeze) begin
      div_reg   <= x64_tick ? i_divide : div_reg - 8'h01;
      phase_reg <= x64_tick ? phase_reg + 6'h01 : phase_reg;
    end
  end
endmodule // ast_baud_gen

// ---- logic/ast_frame_shifter.sv ----
// internal transmit shifter with its bit count
`timescale 1ns/100ps
`include "ast_map.svh"
module ast_frame_shifter (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // control
  input  wire logic       i_clear,
  input  wire logic       i_load,
  input  wire logic       i_shift,
  input  wire logic       i_nine,
  input  wire logic [8:0] i_data,
  // data out
  output logic            o_bit,
  output logic            o_next,
  output logic            o_last
);
  import ast_pkg::*;

  logic [8:0] sr_reg;
  logic [3:0] cnt_reg;

  assign o_bit  = sr_reg[0];
  assign o_next = sr_reg[1];
  assign o_last = (cnt_reg == 4'h1);

  // load a frame, then shift out least bit first
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      sr_reg  <= 9'h1ff;
      cnt_reg <= 4'h0;
    end else if (i_load) begin
      sr_reg  <= i_data;
      cnt_reg <= i_nine ? `AST_BITS_NINE : `AST_BITS_EIGHT;
    end else if (i_shift) begin
      sr_reg  <= {1'b1, sr_reg[8:1]};
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule // ast_frame_shifter

// ---- logic/ast_map.svh ----
// register map, field positions, reset values and timing counts
`ifndef AST_MAP_SVH
`define AST_MAP_SVH

// ****************************************************************
// bus widths and answers
// ****************************************************************
`define AST_ADDR_W        8
`define AST_RESP_OKAY     2'b00
`define AST_RESP_SLVERR   2'b10

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define AST_IDX_RCV_CTRL  6'h13
`define AST_IDX_TX_CTRL   6'h15
`define AST_IDX_HOLDING   6'h16
`define AST_IDX_BAUD      6'h17
`define AST_IDX_FLAGS     6'h18
`define AST_IDX_IRQ_EN    6'h19

// ****************************************************************
// field positions
// ****************************************************************
`define AST_TX_CLK_ORIGIN 7
`define AST_TX_NINE_SEL   6
`define AST_TX_ENABLE     5
`define AST_TX_SYNC_MODE  4
`define AST_TX_SHIFT_EMPTY 1
`define AST_TX_NINTH_BIT  0
`define AST_RC_PORT_EN    7
`define AST_RC_SINGLE_RX  5
`define AST_RC_CONT_RX    4
`define AST_FLAG_TX_EMPTY 1

// ****************************************************************
// reset values
// ****************************************************************
`define AST_RST_BAUD      8'h00
`define AST_RST_HOLDING   8'h00
`define AST_RST_TX_EMPTY  1'b1

// ****************************************************************
// timing counts
// ****************************************************************
`define AST_PHASE_LAST    6'h3f
`define AST_BITS_EIGHT    4'h8
`define AST_BITS_NINE     4'h9

`endif

// ---- logic/ast_pkg.sv ----
// types shared by the transmitter files
`include "ast_map.svh"
package ast_pkg;

  typedef enum logic [2:0] {
    AST_IDLE  = 3'b000,
    AST_READY = 3'b001,
    AST_START = 3'b010,
    AST_DATA  = 3'b011,
    AST_STOP  = 3'b100
  } ast_state_t;

  typedef struct packed {
    logic [`AST_ADDR_W-1:0] awaddr;
    logic                   awvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   wvalid;
    logic                   bready;
  } ast_wr_req_t;

  typedef struct packed {
    logic       awready;
    logic       wready;
    logic [1:0] bresp;
    logic       bvalid;
  } ast_wr_rsp_t;

  typedef struct packed {
    logic [`AST_ADDR_W-1:0] araddr;
    logic                   arvalid;
    logic                   rready;
  } ast_rd_req_t;

  typedef struct packed {
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ast_rd_rsp_t;

endpackage

// ---- logic/ast_top.sv ----
// asynchronous serial transmitter with its register slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "ast_map.svh"
module ast_top (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // register bus
  input  wire ast_pkg::ast_wr_req_t i_wr,
  output ast_pkg::ast_wr_rsp_t    o_wr,
  input  wire ast_pkg::ast_rd_req_t i_rd,
  output ast_pkg::ast_rd_rsp_t    o_rd,
  // device state
  input  wire logic               i_sleep,
  // transmit/clock pin
  output logic                    o_tx_pin_out,
  output logic                    o_tx_pin_oe_n,
  // receive/data pin
  output logic                    o_rx_pin_out,
  output logic                    o_rx_pin_oe_n
);
  import ast_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  // bus slave state
  logic                   aw_held_reg;
  logic [`AST_ADDR_W-1:0] aw_addr_reg;
  logic                   w_held_reg;
  logic [7:0]             w_data_reg;
  logic                   w_lane0_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [31:0]            rdata_reg;

  // software-visible control
  logic       clk_origin_reg;
  logic       nine_sel_reg;
  logic       tx_enable_reg;
  logic       sync_mode_reg;
  logic       ninth_bit_reg;
  logic       port_en_reg;
  logic       single_rx_reg;
  logic       cont_rx_reg;
  logic [7:0] baud_reg;
  logic       irq_en_reg;

  // transmit path state
  logic [7:0] hold_reg;
  logic       hold_full_reg;
  logic       tx_empty_flag_reg;
  ast_state_t state_reg;
  ast_state_t state_next;
  logic       line_reg;
  logic       line_next;

  // pin registers
  logic       tx_oe_n_reg;
  logic       rx_oe_n_reg;

  // decode and control wires
  logic       wr_fire;
  logic       wr_sel_tx_ctrl;
  logic       wr_sel_rcv_ctrl;
  logic       wr_sel_holding;
  logic       wr_sel_baud;
  logic       wr_sel_flags;
  logic       wr_sel_irq_en;
  logic       wr_mapped;
  logic       wr_lane_ok;
  logic       rd_fire;
  logic [5:0] rd_idx;
  logic       rd_mapped;
  logic [7:0] rd_byte;
  logic [7:0] tx_ctrl_view;
  logic [7:0] rcv_ctrl_view;
  logic       shift_empty;
  logic       tx_run;
  logic       bit_tick;
  logic       do_load;
  logic       do_shift;
  logic       sh_bit;
  logic       sh_next;
  logic       sh_last;
  logic       tx_pin_drive;
  logic       rx_pin_drive;

  // ****************************************************************
  // bus slave: write and read channels
  // ****************************************************************
  // a write completes once both address and data have been taken
  assign wr_fire    = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_lane_ok = wr_fire && w_lane0_reg;

  // write address decode on the word index
  assign wr_sel_tx_ctrl  = (aw_addr_reg[7:2] == `AST_IDX_TX_CTRL);
  assign wr_sel_rcv_ctrl = (aw_addr_reg[7:2] == `AST_IDX_RCV_CTRL);
  assign wr_sel_holding  = (aw_addr_reg[7:2] == `AST_IDX_HOLDING);
  assign wr_sel_baud     = (aw_addr_reg[7:2] == `AST_IDX_BAUD);
  assign wr_sel_flags    = (aw_addr_reg[7:2] == `AST_IDX_FLAGS);
  assign wr_sel_irq_en   = (aw_addr_reg[7:2] == `AST_IDX_IRQ_EN);
  assign wr_mapped = wr_sel_tx_ctrl || wr_sel_rcv_ctrl || wr_sel_holding
                  || wr_sel_baud || wr_sel_flags || wr_sel_irq_en;

  // address and data channels are taken in either order
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else begin
      if (i_wr.awvalid && !aw_held_reg && !bvalid_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= i_wr.awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (i_wr.wvalid && !w_held_reg && !bvalid_reg) begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= i_wr.wdata[7:0];
        w_lane0_reg <= i_wr.wstrb[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response, held until the master takes it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `AST_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
    end else if (bvalid_reg && i_wr.bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read decode; the shifter itself has no index at all
  assign rd_fire   = i_rd.arvalid && !rvalid_reg;
  assign rd_idx    = i_rd.araddr[7:2];
  assign shift_empty   = (state_reg == AST_IDLE);
  assign tx_ctrl_view  = {clk_origin_reg, nine_sel_reg, tx_enable_reg,
                          sync_mode_reg, 2'b00, shift_empty,
                          ninth_bit_reg};
  assign rcv_ctrl_view = {port_en_reg, 1'b0, single_rx_reg, cont_rx_reg,
                          4'h0};
  assign rd_mapped = (rd_idx == `AST_IDX_TX_CTRL)
                  || (rd_idx == `AST_IDX_RCV_CTRL)
                  || (rd_idx == `AST_IDX_HOLDING)
                  || (rd_idx == `AST_IDX_BAUD)
                  || (rd_idx == `AST_IDX_FLAGS)
                  || (rd_idx == `AST_IDX_IRQ_EN);
  assign rd_byte =
      (rd_idx == `AST_IDX_TX_CTRL)  ? tx_ctrl_view :
      (rd_idx == `AST_IDX_RCV_CTRL) ? rcv_ctrl_view :
      (rd_idx == `AST_IDX_HOLDING)  ? hold_reg :
      (rd_idx == `AST_IDX_BAUD)     ? baud_reg :
      (rd_idx == `AST_IDX_FLAGS)    ? {6'h00, tx_empty_flag_reg, 1'b0} :
      (rd_idx == `AST_IDX_IRQ_EN)   ? {6'h00, irq_en_reg, 1'b0} :
      8'h00;

  // read data channel
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `AST_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_mapped ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
      rdata_reg  <= {24'h00_0000, rd_byte};
    end else if (rvalid_reg && i_rd.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // answers straight from registers, readies gated from them
  assign o_wr.awready = !aw_held_reg && !bvalid_reg;
  assign o_wr.wready  = !w_held_reg && !bvalid_reg;
  assign o_wr.bvalid  = bvalid_reg;
  assign o_wr.bresp   = bresp_reg;
  assign o_rd.arready = !rvalid_reg;
  assign o_rd.rvalid  = rvalid_reg;
  assign o_rd.rresp   = rresp_reg;
  assign o_rd.rdata   = rdata_reg;

  // ****************************************************************
  // control registers
  // ****************************************************************
  // mode and option bits; the shift-empty bit ignores writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clk_origin_reg <= 1'b0;
      nine_sel_reg   <= 1'b0;
      tx_enable_reg  <= 1'b0;
      sync_mode_reg  <= 1'b0;
      ninth_bit_reg  <= 1'b0;
      port_en_reg    <= 1'b0;
      single_rx_reg  <= 1'b0;
      cont_rx_reg    <= 1'b0;
      baud_reg       <= `AST_RST_BAUD;
      irq_en_reg     <= 1'b0;
    end else if (wr_lane_ok) begin
      if (wr_sel_tx_ctrl) begin
        clk_origin_reg <= w_data_reg[`AST_TX_CLK_ORIGIN];
        nine_sel_reg   <= w_data_reg[`AST_TX_NINE_SEL];
        tx_enable_reg  <= w_data_reg[`AST_TX_ENABLE];
        sync_mode_reg  <= w_data_reg[`AST_TX_SYNC_MODE];
        ninth_bit_reg  <= w_data_reg[`AST_TX_NINTH_BIT];
      end
      if (wr_sel_rcv_ctrl) begin
        port_en_reg   <= w_data_reg[`AST_RC_PORT_EN];
        single_rx_reg <= w_data_reg[`AST_RC_SINGLE_RX];
        cont_rx_reg   <= w_data_reg[`AST_RC_CONT_RX];
      end
      if (wr_sel_baud) begin
        baud_reg <= w_data_reg;
      end
      if (wr_sel_irq_en) begin
        irq_en_reg <= w_data_reg[`AST_FLAG_TX_EMPTY];
      end
    end
  end

  // ****************************************************************
  // holding register and empty flag
  // ****************************************************************
  // load wins over a same-cycle write for the flag; new data stays held
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hold_reg          <= `AST_RST_HOLDING;
      hold_full_reg     <= 1'b0;
      tx_empty_flag_reg <= `AST_RST_TX_EMPTY;
    end else begin
      if (wr_lane_ok && wr_sel_holding) begin
        hold_reg      <= w_data_reg;
        hold_full_reg <= 1'b1;
      end else if (do_load) begin
        hold_full_reg <= 1'b0;
      end
      if (do_load) begin
        tx_empty_flag_reg <= 1'b1;
      end else if (wr_lane_ok && wr_sel_holding) begin
        tx_empty_flag_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // transmit sequencer
  // ****************************************************************
  // runs only in async mode with both enables set; clock origin unused
  assign tx_run = port_en_reg && tx_enable_reg && !sync_mode_reg;

  ast_baud_gen u_baud (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_enable   (tx_run),
    .i_freeze   (i_sleep),
    .i_divide   (baud_reg),
    .o_bit_tick (bit_tick)
  );

  // next state and line level; parity is never formed here
  always_comb begin
    state_next = state_reg;
    line_next  = line_reg;
    do_load    = 1'b0;
    do_shift   = 1'b0;
    if (!tx_run) begin
      state_next = AST_IDLE;
      line_next  = 1'b1;
    end else if (!i_sleep) begin
      unique case (state_reg)
        AST_IDLE: begin
          if (hold_full_reg) begin
            do_load    = 1'b1;
            state_next = AST_READY;
          end
        end
        AST_READY: begin
          if (bit_tick) begin
            state_next = AST_START;
            line_next  = 1'b0;
          end
        end
        AST_START: begin
          if (bit_tick) begin
            state_next = AST_DATA;
            line_next  = sh_bit;
          end
        end
        AST_DATA: begin
          if (bit_tick) begin
            do_shift = 1'b1;
            if (sh_last) begin
              state_next = AST_STOP;
              line_next  = 1'b1;
            end else begin
              line_next = sh_next;
            end
          end
        end
        AST_STOP: begin
          if (bit_tick) begin
            if (hold_full_reg) begin
              do_load    = 1'b1;
              state_next = AST_START;
              line_next  = 1'b0;
            end else begin
              state_next = AST_IDLE;
            end
          end
        end
        default: begin
          state_next = AST_IDLE;
          line_next  = 1'b1;
        end
      endcase
    end
  end

  // sequencer state and line register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= AST_IDLE;
      line_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      line_reg  <= line_next;
    end
  end

  ast_frame_shifter u_shift (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (!tx_run),
    .i_load  (do_load),
    .i_shift (do_shift),
    .i_nine  (nine_sel_reg),
    .i_data  ({ninth_bit_reg, hold_reg}),
    .o_bit   (sh_bit),
    .o_next  (sh_next),
    .o_last  (sh_last)
  );

  // ****************************************************************
  // pin direction
  // ****************************************************************
  // async: tx pin driven while running, rx pin always an input
  assign tx_pin_drive = port_en_reg &&
      (sync_mode_reg ? clk_origin_reg : tx_enable_reg);
  assign rx_pin_drive = port_en_reg && sync_mode_reg && tx_enable_reg
                     && !single_rx_reg && !cont_rx_reg;

  // registered pin controls; enables are low while driving
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_oe_n_reg <= 1'b1;
      rx_oe_n_reg <= 1'b1;
    end else begin
      tx_oe_n_reg <= !tx_pin_drive;
      rx_oe_n_reg <= !rx_pin_drive;
    end
  end

  assign o_tx_pin_out  = line_reg;
  assign o_tx_pin_oe_n = tx_oe_n_reg;
  assign o_rx_pin_out  = line_reg;
  assign o_rx_pin_oe_n = rx_oe_n_reg;

endmodule // ast_top
